/* hdl/rxfbg_pkg.sv */
// Purpose: Shared constants and carriers for the receive frame buffer guard
// Assumes: 200 MHz device clock, 8-bit register port, 128-byte frame buffer
// Notes:   All offsets, reset values and cycle counts live here
package rxfbg_pkg;

	// ==========================================================
	// Register map
	localparam logic [5:0] TRX_CTRL1_ADDR   = 6'h04;
	localparam logic [5:0] START_DELIM_ADDR = 6'h0B;
	localparam logic [5:0] TRX_CTRL2_ADDR   = 6'h0C;
	localparam logic [7:0] TRX_CTRL1_RST    = 8'h20;
	localparam logic [7:0] TRX_CTRL2_RST    = 8'h20;
	localparam logic [7:0] START_DELIM_RST  = 8'hA7;
	localparam int         EMPTY_EN_BIT     = 4;
	localparam int         SAFE_MODE_BIT    = 7;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS   = 5;
	localparam int EMPTY_DELAY_NS  = 750;
	localparam int EMPTY_DLY_CYC   =
		(EMPTY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] EMPTY_DLY_LAST = 8'(EMPTY_DLY_CYC - 1);

	// ==========================================================
	// Delimiter symbol layout
	localparam logic [2:0] BPSK_SYMS  = 3'h7; // Eight symbols, count-1
	localparam logic [2:0] OQPSK_SYMS = 3'h1; // Two symbols, count-1

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] data;
		logic       delim; // Byte is the delimiter itself
	} rxfbg_fb_wr_s;

	typedef struct packed {
		logic       sel_n;
		logic       sclk;
		logic       mosi;
	} rxfbg_spi_s;

	typedef enum logic [1:0] {
		EMPTY_IDLE,
		EMPTY_WAIT,
		EMPTY_SHOW
	} rxfbg_empty_e;

endpackage

/* hdl/rxfbg_guard.sv */
// Purpose: Frame buffer empty indicator, dynamic protection and delimiter
// Assumes: SPI pins arrive raw; radio and register port run on clk_i
// Notes:   Frame buffer read opcode match is a parameter
// Functional notes
// - Control register 0x04 bit 4 enables empty indication, reset off.
// - During frame buffer read, pin high while next byte unavailable.
// - No interrupt signalling on the pin while it shows empty status.
// - In receive states each new frame overwrites the previous one.
// - Active protection blocks radio writes until chip select rises.
// - Basic mode protects a frame only when its checksum is valid.
// - Extended mode protects a frame when transaction-end event fires.
// - Protection needs 0x0C bit 7 and a receive state; bit resets off.
// - Host writes over SPI still reach the buffer under protection.
// - Protection clears on read-ending chip select rise or leaving RX.
// - Delimiter is one octet: eight BPSK or two O-QPSK symbols.
// - Delimiter octet aligns bytes and is never stored in buffer.
// - Transmit delimiter least significant bit first after preamble.
// - Delimiter register at 0x0B, reset 0xA7, any value accepted.
// - Receive-start only on delimiter match and valid header.
// - Empty indication takes effect 750 ns after command byte.
// - After chip select rises, pending interrupts show immediately.
// - Receive error during read locks the indication high.
`timescale 1ns/10ps
module rxfbg_guard
	import rxfbg_pkg::*;
#(
	parameter logic [7:0] FB_RD_MASK = 8'hE0,
	parameter logic [7:0] FB_RD_CODE = 8'h20
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire rxfbg_spi_s   spi_i,
	input  wire logic         reg_wr_i,
	input  wire logic         reg_rd_i,
	input  wire logic [5:0]   reg_addr_i,
	input  wire logic [7:0]   reg_wdata_i,
	output logic      [7:0]   reg_rdata_o,
	input  wire logic         rx_on_i,
	input  wire logic         rx_auto_ack_state_i,
	input  wire logic         frame_done_i,
	input  wire logic         fcs_ok_i,
	input  wire logic         txn_end_event_i,
	input  wire logic         rx_error_i,
	input  wire logic         fb_avail_i,
	input  wire logic         irq_pending_i,
	output logic              irq_o,
	input  wire logic         air_wr_i,
	input  wire rxfbg_fb_wr_s air_wr_data_i,
	input  wire logic         host_wr_i,
	input  wire rxfbg_fb_wr_s host_wr_data_i,
	output logic              fb_we_o,
	output rxfbg_fb_wr_s      fb_wr_o,
	output logic              protect_o,
	input  wire logic         sfd_rx_i,
	input  wire logic [7:0]   sfd_rx_byte_i,
	input  wire logic         phr_valid_i,
	output logic              rx_start_o,
	input  wire logic         bpsk_i,
	input  wire logic         tx_start_i,
	input  wire logic         tx_sym_tick_i,
	output logic      [3:0]   tx_sym_o,
	output logic              tx_busy_o
);

	// ==========================================================
	// Registers
	logic [7:0]   transceiver_control_1;
	logic [7:0]   transceiver_control_2;
	logic [7:0]   start_delimiter_value;
	rxfbg_spi_s   sync1, sync2, sync3, spi_f, spi_p;
	logic [7:0]   cmd_sh;
	logic [2:0]   cmd_cnt;
	logic         cmd_done;
	logic         fb_cmd;
	rxfbg_empty_e empty_st;
	logic [7:0]   dly_cnt;
	logic         err_lock;
	logic         in_rx_p;
	logic         sfd_ok;
	logic [7:0]   tx_sh;
	logic [2:0]   tx_left;

	wire fb_en    = transceiver_control_1[EMPTY_EN_BIT];
	wire safe_en  = transceiver_control_2[SAFE_MODE_BIT];
	wire in_rx    = rx_on_i | rx_auto_ack_state_i;
	wire sel_rise = spi_f.sel_n & ~spi_p.sel_n;
	wire sel_fall = ~spi_f.sel_n & spi_p.sel_n;
	wire clk_rise = spi_f.sclk & ~spi_p.sclk & ~spi_f.sel_n;
	wire fb_end   = sel_rise & (empty_st != EMPTY_IDLE);
	wire prot_set = safe_en &
		((rx_on_i & frame_done_i & fcs_ok_i) |
		 (rx_auto_ack_state_i & txn_end_event_i));

	// Register writes; the addressed register takes the whole byte, others keep their value
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			transceiver_control_1 <= TRX_CTRL1_RST;
			transceiver_control_2 <= TRX_CTRL2_RST;
			start_delimiter_value <= START_DELIM_RST;
		end else if (reg_wr_i) begin
			unique case (reg_addr_i)
				TRX_CTRL1_ADDR:   transceiver_control_1 <= reg_wdata_i;
				TRX_CTRL2_ADDR:   transceiver_control_2 <= reg_wdata_i;
				START_DELIM_ADDR: start_delimiter_value <= reg_wdata_i;
				default:          ;
			endcase
		end
	end

	// Read data held until the next read; unmapped reads give zero
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				TRX_CTRL1_ADDR:   reg_rdata_o <= transceiver_control_1;
				TRX_CTRL2_ADDR:   reg_rdata_o <= transceiver_control_2;
				START_DELIM_ADDR: reg_rdata_o <= start_delimiter_value;
				default:          reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// ==========================================================
	// SPI pin sampling: three stages, change taken once 2nd and 3rd agree
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1 <= 3'b100;
			sync2 <= 3'b100;
			sync3 <= 3'b100;
			spi_f <= 3'b100;
			spi_p <= 3'b100;
		end else begin
			sync1 <= spi_i;
			sync2 <= sync1;
			sync3 <= sync2;
			spi_f <= (sync2 ~^ sync3) & sync3 | (sync2 ^ sync3) & spi_f;
			spi_p <= spi_f;
		end
	end

	// Command byte capture, MSB first on SCLK rising edges
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cmd_sh   <= 8'h00;
			cmd_cnt  <= 3'h0;
			cmd_done <= 1'b0;
			fb_cmd   <= 1'b0;
		end else begin
			fb_cmd <= 1'b0;
			if (sel_fall) begin
				cmd_cnt  <= 3'h0;
				cmd_done <= 1'b0;
			end else if (clk_rise && !cmd_done) begin
				cmd_sh  <= {cmd_sh[6:0], spi_f.mosi};
				cmd_cnt <= cmd_cnt + 3'h1;
				if (cmd_cnt == 3'h7) begin
					cmd_done <= 1'b1;
					fb_cmd   <= (({cmd_sh[6:0], spi_f.mosi} & FB_RD_MASK)
						== FB_RD_CODE);
				end
			end
		end
	end

	// ==========================================================
	// Empty indicator session; delay counted from the last command edge
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			empty_st <= EMPTY_IDLE;
			dly_cnt  <= 8'h00;
		end else if (sel_rise) begin
			empty_st <= EMPTY_IDLE;
		end else begin
			unique case (empty_st)
				EMPTY_IDLE: if (fb_cmd) begin
					empty_st <= EMPTY_WAIT;
					dly_cnt  <= 8'h00;
				end
				EMPTY_WAIT: begin
					dly_cnt <= dly_cnt + 8'h01;
					if (dly_cnt == EMPTY_DLY_LAST)
						empty_st <= EMPTY_SHOW;
				end
				EMPTY_SHOW: ;
			endcase
		end
	end

	// Error lock: a stuck-high pin lets the host time out and abort
	// Idle also clears, so a lock caught on the final edge cannot leak
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			err_lock <= 1'b0;
		else if (rx_error_i && empty_st != EMPTY_IDLE)
			err_lock <= 1'b1;
		else if (sel_rise || empty_st == EMPTY_IDLE)
			err_lock <= 1'b0;
	end

	// Pin mux; interrupts muted for the whole read once enabled
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			irq_o <= 1'b0;
		else if (fb_en && empty_st == EMPTY_SHOW)
			irq_o <= err_lock | ~fb_avail_i;
		else if (fb_en && empty_st == EMPTY_WAIT)
			irq_o <= 1'b0;
		else
			irq_o <= irq_pending_i;
	end

	// ==========================================================
	// Dynamic protection; a new set outranks a same-cycle clear
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			protect_o <= 1'b0;
			in_rx_p   <= 1'b0;
		end else begin
			in_rx_p <= in_rx;
			if (prot_set && in_rx)
				protect_o <= 1'b1;
			else if (fb_end || (in_rx_p && !in_rx) || !safe_en)
				protect_o <= 1'b0;
		end
	end

	// Buffer write port; host wins a collision, radio bytes then drop
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fb_we_o <= 1'b0;
			fb_wr_o <= '0;
		end else if (host_wr_i) begin
			fb_we_o <= 1'b1;
			fb_wr_o <= host_wr_data_i;
		end else begin
			fb_we_o <= air_wr_i && !protect_o
				&& !air_wr_data_i.delim;
			fb_wr_o <= air_wr_data_i;
		end
	end

	// ==========================================================
	// Receive start: delimiter match remembered until the header check
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sfd_ok     <= 1'b0;
			rx_start_o <= 1'b0;
		end else begin
			rx_start_o <= phr_valid_i & sfd_ok;
			if (sfd_rx_i)
				sfd_ok <= (sfd_rx_byte_i == start_delimiter_value);
			else if (phr_valid_i)
				sfd_ok <= 1'b0;
		end
	end

	// Transmit delimiter; first symbol presented with the start pulse
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_sh     <= 8'h00;
			tx_left   <= 3'h0;
			tx_busy_o <= 1'b0;
			tx_sym_o  <= 4'h0;
		end else if (tx_start_i) begin
			tx_busy_o <= 1'b1;
			tx_left   <= bpsk_i ? BPSK_SYMS : OQPSK_SYMS;
			tx_sym_o  <= bpsk_i ? {3'h0, start_delimiter_value[0]}
				: start_delimiter_value[3:0];
			tx_sh     <= bpsk_i ? {1'b0, start_delimiter_value[7:1]}
				: {4'h0, start_delimiter_value[7:4]};
		end else if (tx_busy_o && tx_sym_tick_i) begin
			if (tx_left == 3'h0) begin
				tx_busy_o <= 1'b0;
			end else begin
				tx_left  <= tx_left - 3'h1;
				tx_sym_o <= bpsk_i ? {3'h0, tx_sh[0]} : tx_sh[3:0];
				tx_sh    <= bpsk_i ? {1'b0, tx_sh[7:1]} : {4'h0, tx_sh[7:4]};
			end
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_wait_done;
		empty_st == EMPTY_WAIT && dly_cnt == EMPTY_DLY_LAST && !sel_rise;
	endsequence
	sequence s_frame_ok;
		prot_set && in_rx;
	endsequence

	a_empty_delay: assert property (
		$rose(empty_st == EMPTY_SHOW) |-> $past(dly_cnt) == EMPTY_DLY_LAST)
		else $error("empty indication not after delay");
	a_wait_to_show: assert property (s_wait_done |=> empty_st == EMPTY_SHOW)
		else $error("wait did not end in show");
	a_empty_pin: assert property ((fb_en && empty_st == EMPTY_SHOW)
		|=> irq_o == ($past(err_lock) | ~$past(fb_avail_i)))
		else $error("empty pin mismatch");
	a_irq_mute: assert property (
		(fb_en && empty_st == EMPTY_WAIT) |=> !irq_o)
		else $error("interrupt shown while muted");
	a_irq_return: assert property (
		(empty_st == EMPTY_IDLE && !fb_cmd) |=> irq_o == $past(irq_pending_i))
		else $error("pending interrupt not shown");
	a_err_lock: assert property (
		(rx_error_i && fb_en && empty_st == EMPTY_SHOW && !sel_rise)
		|=> ##1 irq_o)
		else $error("error lock not high");
	a_prot_set: assert property (s_frame_ok |=> protect_o)
		else $error("protection not set");
	a_prot_block: assert property (
		(protect_o && air_wr_i && !host_wr_i) |=> !fb_we_o)
		else $error("radio write under protection");
	a_host_pass: assert property (
		host_wr_i |=> fb_we_o && fb_wr_o == $past(host_wr_data_i))
		else $error("host write lost");
	a_prot_clear: assert property (
		((fb_end || (in_rx_p && !in_rx)) && !(prot_set && in_rx))
		|=> !protect_o)
		else $error("protection not cleared");
	a_rx_start: assert property (
		rx_start_o |-> $past(phr_valid_i) && $past(sfd_ok))
		else $error("receive start without match");
	a_tx_lsb: assert property (
		(tx_start_i && bpsk_i) |=> tx_busy_o
		&& ({7'h00, tx_sym_o[0]} == ($past(start_delimiter_value) & 8'h01)))
		else $error("delimiter not lsb first");
	a_no_delim: assert property (
		(air_wr_i && air_wr_data_i.delim && !host_wr_i) |=> !fb_we_o)
		else $error("delimiter stored");
endmodule

/* sim/rxfbg_host_model.sv */
// Purpose: Host controller model driving the raw SPI pins
// Assumes: 125 ns link clock, clock parked low between frames
// Notes:   Only command bytes are clocked; data phase is not modelled
`timescale 1ns/10ps
module rxfbg_host_model
	import rxfbg_pkg::*;
(
	output rxfbg_spi_s spi_o
);
	// ==================
	// Idle: deselected, clock still
	initial begin
		spi_o = '{sel_n: 1'b1, sclk: 1'b0, mosi: 1'b1};
	end

	// Command byte MSB first; idle gap before select
	task automatic send_cmd(input logic [7:0] cmd);
		#250;
		spi_o.sel_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			spi_o.mosi = cmd[i];
			#62.5;
			spi_o.sclk = 1'b1;
			#62.5;
			spi_o.sclk = 1'b0;
		end
		spi_o.mosi = ~spi_o.mosi; // Not driven data, keep it moving
	endtask

	// Deselect at once, so the read is always ended
	task automatic end_read();
		spi_o.sel_n = 1'b1;
		spi_o.mosi = ~spi_o.mosi;
	endtask
endmodule

/* sim/tb_rx_frame_buffer_guard_and_sfd.sv */
// Purpose: Self-checking bench for the frame buffer guard
// Assumes: Fixed latencies as handed over, 200 MHz clock
// Notes:   Inputs move 1 ns after the rising edge, except the SPI pins driven by the host model
`timescale 1ns/10ps
module tb_rx_frame_buffer_guard_and_sfd
	import rxfbg_pkg::*;
;
	// ==================
	// Signals
	localparam logic [7:0] delim_val = 8'h5C;
	logic clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic rx_on_i = 1'b0, rx_auto_ack_state_i = 1'b0, frame_done_i = 1'b0;
	logic fcs_ok_i = 1'b0, txn_end_event_i = 1'b0, rx_error_i = 1'b0;
	logic fb_avail_i = 1'b0, irq_pending_i = 1'b0, air_wr_i = 1'b0;
	logic host_wr_i = 1'b0, sfd_rx_i = 1'b0, phr_valid_i = 1'b0;
	logic bpsk_i = 1'b0, tx_start_i = 1'b0, tx_sym_tick_i = 1'b0;
	logic [5:0]   reg_addr_i = 6'h00;
	logic [7:0]   reg_wdata_i = 8'h00, sfd_rx_byte_i = 8'h00;
	logic [7:0]   reg_rdata_o;
	logic         irq_o, fb_we_o, protect_o, rx_start_o, tx_busy_o;
	logic [3:0]   tx_sym_o;
	rxfbg_spi_s   spi;
	rxfbg_fb_wr_s air_wr_data_i = '0, host_wr_data_i = '0, fb_wr_o;
	int           n_errors = 0, n_compared = 0;

	// ==================
	// Design and host
	rxfbg_guard i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .spi_i(spi),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.rx_on_i(rx_on_i), .rx_auto_ack_state_i(rx_auto_ack_state_i),
		.frame_done_i(frame_done_i), .fcs_ok_i(fcs_ok_i),
		.txn_end_event_i(txn_end_event_i), .rx_error_i(rx_error_i),
		.fb_avail_i(fb_avail_i), .irq_pending_i(irq_pending_i),
		.irq_o(irq_o), .air_wr_i(air_wr_i), .air_wr_data_i(air_wr_data_i),
		.host_wr_i(host_wr_i), .host_wr_data_i(host_wr_data_i),
		.fb_we_o(fb_we_o), .fb_wr_o(fb_wr_o), .protect_o(protect_o),
		.sfd_rx_i(sfd_rx_i), .sfd_rx_byte_i(sfd_rx_byte_i),
		.phr_valid_i(phr_valid_i), .rx_start_o(rx_start_o),
		.bpsk_i(bpsk_i), .tx_start_i(tx_start_i),
		.tx_sym_tick_i(tx_sym_tick_i), .tx_sym_o(tx_sym_o),
		.tx_busy_o(tx_busy_o));
	rxfbg_host_model i_host (.spi_o(spi));

	// ==================
	// Shared tasks
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic chk8(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		cyc(1);
		reg_wr_i = 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		cyc(1);
		reg_rd_i = 1'b0;
		chk8("reg rdata", e, reg_rdata_o);
		cyc(1); // Strobe stays low across one edge before the next read
	endtask
	// Radio (h=0) or host (h=1) buffer write, expected enable e
	task automatic aw(input logic h, input logic dl, input logic e);
		air_wr_data_i = '{addr: 7'h05, data: 8'h3C, delim: dl};
		host_wr_data_i = '{addr: 7'h06, data: 8'hC3, delim: 1'b0};
		air_wr_i = !h;
		host_wr_i = h;
		cyc(1);
		air_wr_i = 1'b0;
		host_wr_i = 1'b0;
		chk1("fb we", e, fb_we_o);
		if (e) chk8("fb data", h ? 8'hC3 : 8'h3C, fb_wr_o.data);
		cyc(1); // Strobes stay low across one edge before the next write
	endtask
	task automatic frame(input logic ok);
		frame_done_i = 1'b1;
		fcs_ok_i = ok;
		cyc(1);
		frame_done_i = 1'b0;
		chk1("protect", ok, protect_o);
	endtask
	task automatic sfd(input logic [7:0] b, input logic e);
		sfd_rx_byte_i = b;
		sfd_rx_i = 1'b1;
		cyc(1);
		sfd_rx_i = 1'b0;
		cyc(2);
		phr_valid_i = 1'b1;
		cyc(1);
		phr_valid_i = 1'b0;
		chk1("rx start", e, rx_start_o);
	endtask
	// Symbols must come LSB first, one per tick
	task automatic tx(input logic b, input int n);
		bpsk_i = b;
		tx_start_i = 1'b1;
		cyc(1);
		tx_start_i = 1'b0;
		for (int i = 0; i < n; i++) begin
			chk1("tx busy", 1'b1, tx_busy_o);
			if (b) chk1("tx bit", delim_val[i], tx_sym_o[0]);
			else chk8("tx sym", {4'h0, delim_val[4*i +: 4]},
				{4'h0, tx_sym_o});
			cyc(3);
			tx_sym_tick_i = 1'b1;
			cyc(1);
			tx_sym_tick_i = 1'b0;
		end
		chk1("tx busy", 1'b0, tx_busy_o);
	endtask

	// ==================
	// Scenarios
	task automatic t_regs();
		rd(TRX_CTRL1_ADDR, TRX_CTRL1_RST);
		rd(START_DELIM_ADDR, START_DELIM_RST);
		rd(TRX_CTRL2_ADDR, TRX_CTRL2_RST);
		rd(6'h3F, 8'h00);
		wr(START_DELIM_ADDR, delim_val);
		rd(START_DELIM_ADDR, delim_val);
		wr(TRX_CTRL1_ADDR, 8'h3B);
		rd(TRX_CTRL1_ADDR, 8'h3B);
		$display("test regs done");
	endtask
	task automatic t_empty();
		irq_pending_i = 1'b1;
		i_host.send_cmd(8'h20);
		cyc(125);
		chk1("irq in wait", 1'b0, irq_o);
		cyc(35);
		chk1("irq empty", 1'b1, irq_o);
		fb_avail_i = 1'b1;
		cyc(3);
		chk1("irq avail", 1'b0, irq_o);
		rx_error_i = 1'b1;
		cyc(1);
		rx_error_i = 1'b0;
		cyc(3);
		chk1("irq lock", 1'b1, irq_o);
		irq_pending_i = 1'b0;
		i_host.end_read();
		cyc(8);
		chk1("irq back", 1'b0, irq_o);
		irq_pending_i = 1'b1;
		cyc(2);
		chk1("irq pend", 1'b1, irq_o);
		wr(TRX_CTRL1_ADDR, 8'h2B);
		i_host.send_cmd(8'h20);
		cyc(170);
		chk1("irq disabled", 1'b1, irq_o);
		i_host.end_read();
		fb_avail_i = 1'b0;
		$display("test empty done");
	endtask
	task automatic t_protect();
		wr(TRX_CTRL2_ADDR, 8'h25);
		rx_on_i = 1'b1;
		frame_done_i = 1'b1;
		fcs_ok_i = 1'b1;
		cyc(1);
		frame_done_i = 1'b0;
		chk1("protect off", 1'b0, protect_o);
		wr(TRX_CTRL2_ADDR, 8'hA5);
		frame(1'b0);
		aw(1'b0, 1'b0, 1'b1);
		aw(1'b0, 1'b1, 1'b0);
		frame(1'b1);
		aw(1'b0, 1'b0, 1'b0);
		aw(1'b1, 1'b0, 1'b1);
		i_host.send_cmd(8'h20);
		i_host.end_read();
		cyc(8);
		chk1("protect end", 1'b0, protect_o);
		aw(1'b0, 1'b0, 1'b1);
		rx_on_i = 1'b0;
		rx_auto_ack_state_i = 1'b1;
		cyc(3);
		txn_end_event_i = 1'b1;
		cyc(1);
		txn_end_event_i = 1'b0;
		chk1("protect ext", 1'b1, protect_o);
		rx_auto_ack_state_i = 1'b0;
		cyc(3);
		chk1("protect exit", 1'b0, protect_o);
		$display("test protect done");
	endtask
	task automatic t_delim();
		sfd(delim_val, 1'b1);
		sfd(8'hA7, 1'b0);
		tx(1'b1, 8);
		tx(1'b0, 2);
		$display("test delimiter done");
	endtask

	// ==================
	// Verdict and run control
	task automatic print_verdict();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Clock, 5 ns period
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	// Hang guard, far beyond the normal run length
	initial begin
		#200000;
		n_errors++;
		print_verdict();
	end
	// Main sequence
	initial begin
		repeat (3) @(posedge clk_i);
		#1;
		rst_n_i = 1'b1;
		cyc(5);
		t_regs();
		t_empty();
		t_protect();
		t_delim();
		print_verdict();
	end
endmodule
